// ===== hw/sphc_pkg.sv
// Shared constants and types for the strobed handshake port control block.
// Assumes a single clock domain; pins are synchronised inside the top module.
package sphc_pkg;

  // ==========================================================================
  // Host register addresses
  localparam logic [1:0] ADDR_PA = 2'h0;
  localparam logic [1:0] ADDR_PB = 2'h1;
  localparam logic [1:0] ADDR_PC = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;

  // ==========================================================================
  // Control word fields
  localparam int CW_SEL = 7;
  localparam int CW_AMODE_HI = 6;
  localparam int CW_AMODE_LO = 5;
  localparam int CW_PA_IN = 4;
  localparam int CW_PCU_IN = 3;
  localparam int CW_B_STROBED = 2;
  localparam int CW_PB_IN = 1;
  localparam int CW_PCL_IN = 0;
  localparam int BSR_SEL_HI = 3;
  localparam int BSR_SEL_LO = 1;
  localparam int BSR_VAL = 0;
  // All ports input, basic mode
  localparam logic [6:0] CFG_RESET = 7'h1B;

  // ==========================================================================
  // Port C line positions in strobed modes
  localparam logic [2:0] PC_IRQ_REQUEST_B = 3'h0;
  localparam logic [2:0] PC_FULL_B = 3'h1;
  localparam logic [2:0] PC_LINE_B = 3'h2;
  localparam logic [2:0] PC_IRQ_REQUEST_A = 3'h3;
  localparam logic [2:0] PC_STB_A = 3'h4;
  localparam logic [2:0] PC_IBF_A = 3'h5;
  localparam logic [2:0] PC_ACK_A = 3'h6;
  localparam logic [2:0] PC_OBF_A = 3'h7;

  // ==========================================================================
  // Handshake channels
  localparam int NUM_CH = 3;
  localparam int CH_B = 0;
  localparam int CH_AI = 1;
  localparam int CH_AO = 2;
  localparam int PIN_BITS = 24;

  typedef enum logic [1:0] {SPHC_BASIC, SPHC_STROBED, SPHC_BIDIR} sphc_mode_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sphc_bus_req_t;

endpackage : sphc_pkg

// ===== hw/sphc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the bits are independent levels; no bus coherence is promised.
`timescale 1ns/1ps
module sphc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================================
  // Stages
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule : sphc_sync

// ===== hw/sphc_hs.sv
// One strobed handshake channel: buffer-full flag and interrupt request.
// Assumes line_n is already synchronised and host_ev is a one-cycle strobe.
`timescale 1ns/1ps
module sphc_hs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic active,
  input wire logic dir_in,
  input wire logic line_n,
  input wire logic host_ev,
  input wire logic ie,
  input wire logic force_full,
  input wire logic force_irq,
  input wire logic force_val,
  output logic full,
  output logic irq
);

  // ==========================================================================
  // State
  logic full_reg, full_next;
  logic irq_reg, irq_next;
  logic hold_reg, hold_next;
  logic set_ev, clr_ev;

  // Input: line low fills, host read empties; output the other way round
  always_comb begin
    set_ev = dir_in ? !line_n : host_ev;
    clr_ev = dir_in ? host_ev : !line_n;
    full_next = full_reg;
    irq_next = 1'b0;
    hold_next = hold_reg;
    if (clr || !active) begin
      full_next = 1'b0;
      hold_next = 1'b0;
    end else if (force_full) begin
      full_next = force_val || set_ev; // a hardware set still wins
    end else if (set_ev) begin
      full_next = 1'b1; // Set wins over a same-cycle clear
    end else if (clr_ev) begin
      full_next = 1'b0;
    end
    if (set_ev || clr_ev) begin
      hold_next = 1'b0;
    end
    // Level form keeps the request from going stale after a clear
    if (active && !clr) begin
      if (dir_in) begin
        irq_next = full_next && line_n && ie && !host_ev;
      end else begin
        irq_next = !full_next && line_n && ie && !host_ev;
      end
    end
    // A forced request value stays until the next handshake event
    if (active && !clr && force_irq) begin
      irq_next = force_val;
      hold_next = 1'b1;
    end else if (hold_reg && hold_next) begin
      irq_next = irq_reg;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_reg <= 1'b0;
      irq_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      full_reg <= full_next;
      irq_reg <= irq_next;
      hold_reg <= hold_next;
    end
  end

  assign full = full_reg;
  assign irq = irq_reg;

  // ==========================================================================
  // Checks
  ibf_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && dir_in && !line_n && !clr && !force_full |=> full_reg)
    else $error("input flag not set by strobe");
  ibf_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && dir_in && line_n && host_ev && !clr && !force_full |=> !full_reg)
    else $error("input flag not cleared by read");
  obf_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && !dir_in && host_ev && !clr && !force_full |=> full_reg)
    else $error("output flag not set by write");
  irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && ie && line_n && (full_reg == dir_in) && !host_ev && !clr && !force_full
    && !force_irq && !hold_reg |=> irq_reg)
    else $error("request not raised");
  irq_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_ev && !force_irq |=> !irq_reg)
    else $error("request not dropped by host strobe");

endmodule : sphc_hs

// ===== hw/sphc_top.sv
// Strobed handshake port control: three 8-bit ports with basic, strobed
// and bidirectional modes, port C status and single-bit commands.
// Assumes a same-clock host port and asynchronous peripheral pins.
//
// Contract
// - Peripheral strobe low loads port data into the input latch.
// - Input-full rises while strobe is low, falls after host read.
// - Input request: strobe high, full and enable set; cleared by read.
// - Enables: group B at line 2, group A input line 4, output line 6.
// - Output-full line goes low on host write, high on acknowledge low.
// - Output request: acknowledge high, buffer empty, enable set; write clears.
// - Each strobed group has one 8-bit port and three control lines; latched.
// - Ports A and B pick input or output independently in strobed mode.
// - Bidirectional mode is group A only, five port C lines.
// - Bidirectional port A drives only while acknowledge is low.
// - Bidirectional enables: output at line 6, input at line 4.
// - Bidirectional request ORs gated input-full and output-empty.
// - Unused port C lines are plain inputs or outputs per mode word.
// - Port C read shows enable flags at lines 2, 4 and 6.
// - Byte write to port C touches only basic-group output lines.
// - Bit command can write any port C output, handshake ones included.
// - Bit command on input lines is ignored, on strobe/ack sets enables.
// - Bit set enables a request, bit reset disables it.
// - Mode select and reset clear all enable flags.
// - Mode select clears output latches and handshake flags.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sphc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire sphc_pkg::sphc_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic [7:0] pa_pin,
  output logic [7:0] pa_drive,
  output logic pa_en,
  input wire logic [7:0] pb_pin,
  output logic [7:0] pb_drive,
  output logic pb_en,
  input wire logic [7:0] pc_pin,
  output logic [7:0] pc_drive,
  output logic [7:0] pc_en
);

  // ==========================================================================
  // Synchronised pins
  logic [sphc_pkg::PIN_BITS-1:0] pin_sync;
  logic [7:0] pa_sync, pb_sync, pc_sync;
  logic stb_a_n, ack_a_n, line_b_n;

  // Data and control pins resync together so a latch sees aligned data
  sphc_sync #(.W(sphc_pkg::PIN_BITS)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({pc_pin, pb_pin, pa_pin}),
    .q(pin_sync)
  );

  assign pa_sync = pin_sync[7:0];
  assign pb_sync = pin_sync[15:8];
  assign pc_sync = pin_sync[23:16];
  assign stb_a_n = pc_sync[sphc_pkg::PC_STB_A];
  assign ack_a_n = pc_sync[sphc_pkg::PC_ACK_A];
  assign line_b_n = pc_sync[sphc_pkg::PC_LINE_B];

  // ==========================================================================
  // Configuration decode
  logic [6:0] cfg_reg, cfg_next;
  sphc_pkg::sphc_mode_t a_mode;
  logic a_basic, a_bidir, pa_in, pb_in, b_strobed;
  logic [7:0] io_out, grp_basic;

  // Group A mode from two bits; group B never goes bidirectional
  always_comb begin
    if (cfg_reg[sphc_pkg::CW_AMODE_HI]) begin
      a_mode = sphc_pkg::SPHC_BIDIR;
    end else if (cfg_reg[sphc_pkg::CW_AMODE_LO]) begin
      a_mode = sphc_pkg::SPHC_STROBED;
    end else begin
      a_mode = sphc_pkg::SPHC_BASIC;
    end
  end

  assign a_basic = (a_mode == sphc_pkg::SPHC_BASIC);
  assign a_bidir = (a_mode == sphc_pkg::SPHC_BIDIR);
  assign pa_in = cfg_reg[sphc_pkg::CW_PA_IN];
  assign pb_in = cfg_reg[sphc_pkg::CW_PB_IN];
  assign b_strobed = cfg_reg[sphc_pkg::CW_B_STROBED];
  // Nibble direction for lines outside the handshake
  assign io_out = {{4{!cfg_reg[sphc_pkg::CW_PCU_IN]}}, {4{!cfg_reg[sphc_pkg::CW_PCL_IN]}}};
  assign grp_basic = {{4{a_basic}}, {4{!b_strobed}}};

  // ==========================================================================
  // Host strobes
  logic wr_a, wr_b, wr_c, wr_ctl, rd_a, rd_b, rd_c, rd_ctl, mode_set, bsr;
  logic [2:0] bsr_sel;
  logic bsr_val;

  assign wr_a = bus_req.wr && (bus_req.addr == sphc_pkg::ADDR_PA);
  assign wr_b = bus_req.wr && (bus_req.addr == sphc_pkg::ADDR_PB);
  assign wr_c = bus_req.wr && (bus_req.addr == sphc_pkg::ADDR_PC);
  assign wr_ctl = bus_req.wr && (bus_req.addr == sphc_pkg::ADDR_CTRL);
  assign rd_a = bus_req.rd && (bus_req.addr == sphc_pkg::ADDR_PA);
  assign rd_b = bus_req.rd && (bus_req.addr == sphc_pkg::ADDR_PB);
  assign rd_c = bus_req.rd && (bus_req.addr == sphc_pkg::ADDR_PC);
  assign rd_ctl = bus_req.rd && (bus_req.addr == sphc_pkg::ADDR_CTRL);
  assign mode_set = wr_ctl && bus_req.wdata[sphc_pkg::CW_SEL];
  assign bsr = wr_ctl && !bus_req.wdata[sphc_pkg::CW_SEL];
  assign bsr_sel = bus_req.wdata[sphc_pkg::BSR_SEL_HI:sphc_pkg::BSR_SEL_LO];
  assign bsr_val = bus_req.wdata[sphc_pkg::BSR_VAL];

  // ==========================================================================
  // Handshake channels: B, A input, A output
  logic [sphc_pkg::NUM_CH-1:0] ch_active, ch_dir_in, ch_line_n, ch_host_ev;
  logic [sphc_pkg::NUM_CH-1:0] ch_full, ch_irq;
  logic [sphc_pkg::NUM_CH-1:0] force_full, force_irq, force_val;
  logic [sphc_pkg::NUM_CH-1:0] ie_reg, ie_next;

  // Bidirectional mode runs both A channels at once
  assign ch_active[sphc_pkg::CH_B] = b_strobed;
  assign ch_active[sphc_pkg::CH_AI] = (a_mode == sphc_pkg::SPHC_STROBED && pa_in) || a_bidir;
  assign ch_active[sphc_pkg::CH_AO] = (a_mode == sphc_pkg::SPHC_STROBED && !pa_in) || a_bidir;
  assign ch_dir_in = {1'b0, 1'b1, pb_in};
  assign ch_line_n = {ack_a_n, stb_a_n, line_b_n};
  assign ch_host_ev = {wr_a, rd_a, pb_in ? rd_b : wr_b};

  generate
    for (genvar c = 0; c < sphc_pkg::NUM_CH; c++) begin : g_ch
      sphc_hs u_hs (
        .clk(clk),
        .rst_n(rst_n),
        .clr(mode_set),
        .active(ch_active[c]),
        .dir_in(ch_dir_in[c]),
        .line_n(ch_line_n[c]),
        .host_ev(ch_host_ev[c]),
        .ie(ie_reg[c]),
        .force_full(force_full[c]),
        .force_irq(force_irq[c]),
        .force_val(force_val[c]),
        .full(ch_full[c]),
        .irq(ch_irq[c])
      );
    end
  endgenerate

  // ==========================================================================
  // Port C line roles for the current mode pair
  logic [7:0] hs_o, hs_v, ln_pos, ln_ie;

  always_comb begin
    hs_o = 8'h00;
    hs_v = 8'h00;
    ln_pos = 8'h00;
    ln_ie = 8'h00;
    if (ch_active[sphc_pkg::CH_B]) begin
      hs_o[sphc_pkg::PC_IRQ_REQUEST_B] = 1'b1;
      hs_v[sphc_pkg::PC_IRQ_REQUEST_B] = ch_irq[sphc_pkg::CH_B];
      hs_o[sphc_pkg::PC_FULL_B] = 1'b1;
      // Output-full pin is active low, input-full is active high
      hs_v[sphc_pkg::PC_FULL_B] = pb_in ? ch_full[sphc_pkg::CH_B] : !ch_full[sphc_pkg::CH_B];
      ln_pos[sphc_pkg::PC_LINE_B] = 1'b1;
      ln_ie[sphc_pkg::PC_LINE_B] = ie_reg[sphc_pkg::CH_B];
    end
    if (ch_active[sphc_pkg::CH_AI] || ch_active[sphc_pkg::CH_AO]) begin
      hs_o[sphc_pkg::PC_IRQ_REQUEST_A] = 1'b1;
      // Single request for both A directions
      hs_v[sphc_pkg::PC_IRQ_REQUEST_A] = ch_irq[sphc_pkg::CH_AI] || ch_irq[sphc_pkg::CH_AO];
    end
    if (ch_active[sphc_pkg::CH_AI]) begin
      hs_o[sphc_pkg::PC_IBF_A] = 1'b1;
      hs_v[sphc_pkg::PC_IBF_A] = ch_full[sphc_pkg::CH_AI];
      ln_pos[sphc_pkg::PC_STB_A] = 1'b1;
      ln_ie[sphc_pkg::PC_STB_A] = ie_reg[sphc_pkg::CH_AI];
    end
    if (ch_active[sphc_pkg::CH_AO]) begin
      hs_o[sphc_pkg::PC_OBF_A] = 1'b1;
      hs_v[sphc_pkg::PC_OBF_A] = !ch_full[sphc_pkg::CH_AO];
      ln_pos[sphc_pkg::PC_ACK_A] = 1'b1;
      ln_ie[sphc_pkg::PC_ACK_A] = ie_reg[sphc_pkg::CH_AO];
    end
  end

  // ==========================================================================
  // Per-line drive, read-back and byte-write mask
  logic [7:0] pc_latch_reg, pc_latch_next;
  logic [7:0] pc_en_next, pc_drv_next, pc_rd, pcw_mask;

  generate
    for (genvar i = 0; i < 8; i++) begin : g_pc
      assign pc_en_next[i] = hs_o[i] || (!ln_pos[i] && io_out[i]);
      assign pc_drv_next[i] = hs_o[i] ? hs_v[i] : pc_latch_reg[i];
      // Strobe and acknowledge positions read back the enable flags
      assign pc_rd[i] = hs_o[i] ? hs_v[i] :
                        ln_pos[i] ? ln_ie[i] :
                        io_out[i] ? pc_latch_reg[i] : pc_sync[i];
      assign pcw_mask[i] = !hs_o[i] && !ln_pos[i] && io_out[i] && grp_basic[i];
    end
  endgenerate

  // ==========================================================================
  // Data latches, enables and configuration
  logic [7:0] pa_latch_reg, pa_latch_next, pb_latch_reg, pb_latch_next;
  logic [7:0] a_in_reg, a_in_next, b_in_reg, b_in_next;

  always_comb begin
    cfg_next = cfg_reg;
    pa_latch_next = pa_latch_reg;
    pb_latch_next = pb_latch_reg;
    pc_latch_next = pc_latch_reg;
    a_in_next = a_in_reg;
    b_in_next = b_in_reg;
    ie_next = ie_reg;
    force_full = '0;
    force_irq = '0;
    force_val = {sphc_pkg::NUM_CH{bsr_val}};
    // Latch follows the pins for as long as the strobe is low
    if (ch_active[sphc_pkg::CH_AI] && !stb_a_n) begin
      a_in_next = pa_sync;
    end
    if (ch_active[sphc_pkg::CH_B] && pb_in && !line_b_n) begin
      b_in_next = pb_sync;
    end
    if (wr_a) begin
      pa_latch_next = bus_req.wdata;
    end
    if (wr_b) begin
      pb_latch_next = bus_req.wdata;
    end
    if (wr_c) begin
      pc_latch_next = (pc_latch_reg & ~pcw_mask) | (bus_req.wdata & pcw_mask);
    end
    if (bsr) begin
      if (hs_o[bsr_sel]) begin
        if (bsr_sel == sphc_pkg::PC_IRQ_REQUEST_B) begin
          force_irq[sphc_pkg::CH_B] = 1'b1;
        end else if (bsr_sel == sphc_pkg::PC_FULL_B) begin
          force_full[sphc_pkg::CH_B] = 1'b1;
          force_val[sphc_pkg::CH_B] = pb_in ? bsr_val : !bsr_val;
        end else if (bsr_sel == sphc_pkg::PC_IRQ_REQUEST_A) begin
          force_irq[sphc_pkg::CH_AI] = ch_active[sphc_pkg::CH_AI];
          force_irq[sphc_pkg::CH_AO] = ch_active[sphc_pkg::CH_AO];
        end else if (bsr_sel == sphc_pkg::PC_IBF_A) begin
          force_full[sphc_pkg::CH_AI] = 1'b1;
        end else begin
          force_full[sphc_pkg::CH_AO] = 1'b1;
          force_val[sphc_pkg::CH_AO] = !bsr_val;
        end
      end else if (ln_pos[bsr_sel]) begin
        if (bsr_sel == sphc_pkg::PC_LINE_B) begin
          ie_next[sphc_pkg::CH_B] = bsr_val;
        end else if (bsr_sel == sphc_pkg::PC_STB_A) begin
          ie_next[sphc_pkg::CH_AI] = bsr_val;
        end else begin
          ie_next[sphc_pkg::CH_AO] = bsr_val;
        end
      end else if (io_out[bsr_sel]) begin
        pc_latch_next[bsr_sel] = bsr_val; // Input lines stay untouched
      end
    end
    // Mode select wipes every output latch and enable
    if (mode_set) begin
      cfg_next = bus_req.wdata[6:0];
      pa_latch_next = 8'h00;
      pb_latch_next = 8'h00;
      pc_latch_next = 8'h00;
      a_in_next = 8'h00;
      b_in_next = 8'h00;
      ie_next = '0;
    end
  end

  // ==========================================================================
  // Pin drive and read data
  logic pa_en_reg, pa_en_next, pb_en_reg, pb_en_next;
  logic [7:0] pc_drv_reg, pc_en_reg, rdata_reg, rdata_next, pa_rd, pb_rd;

  always_comb begin
    // Tristate in bidirectional mode except during acknowledge
    pa_en_next = a_bidir ? !ack_a_n : !pa_in;
    pb_en_next = !pb_in;
    if (ch_active[sphc_pkg::CH_AI]) begin
      pa_rd = a_in_reg;
    end else begin
      pa_rd = pa_in ? pa_sync : pa_latch_reg;
    end
    if (ch_active[sphc_pkg::CH_B] && pb_in) begin
      pb_rd = b_in_reg;
    end else begin
      pb_rd = pb_in ? pb_sync : pb_latch_reg;
    end
    rdata_next = 8'h00;
    if (rd_a) begin
      rdata_next = pa_rd;
    end else if (rd_b) begin
      rdata_next = pb_rd;
    end else if (rd_c) begin
      rdata_next = pc_rd;
    end else if (rd_ctl) begin
      rdata_next = {1'b1, cfg_reg};
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= sphc_pkg::CFG_RESET;
      pa_latch_reg <= 8'h00;
      pb_latch_reg <= 8'h00;
      pc_latch_reg <= 8'h00;
      a_in_reg <= 8'h00;
      b_in_reg <= 8'h00;
      ie_reg <= '0;
      pa_en_reg <= 1'b0;
      pb_en_reg <= 1'b0;
      pc_en_reg <= 8'h00;
      pc_drv_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      cfg_reg <= cfg_next;
      pa_latch_reg <= pa_latch_next;
      pb_latch_reg <= pb_latch_next;
      pc_latch_reg <= pc_latch_next;
      a_in_reg <= a_in_next;
      b_in_reg <= b_in_next;
      ie_reg <= ie_next;
      pa_en_reg <= pa_en_next;
      pb_en_reg <= pb_en_next;
      pc_en_reg <= pc_en_next;
      pc_drv_reg <= pc_drv_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign pa_drive = pa_latch_reg;
  assign pa_en = pa_en_reg;
  assign pb_drive = pb_latch_reg;
  assign pb_en = pb_en_reg;
  assign pc_drive = pc_drv_reg;
  assign pc_en = pc_en_reg;

  // ==========================================================================
  // Checks
  bidir_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    a_bidir |=> pa_en_reg == !$past(ack_a_n))
    else $error("port A drive not tied to acknowledge");
  ie_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_set |=> ie_reg == '0)
    else $error("enables survive mode select");
  out_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_set |=> pa_latch_reg == 8'h00 && pc_latch_reg == 8'h00 && ch_full == '0)
    else $error("outputs survive mode select");
  byte_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_c |=> ie_reg == $past(ie_reg))
    else $error("port C byte write changed enables");
  flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_c && ch_active[sphc_pkg::CH_AI] |=> rdata_reg[4] == $past(ie_reg[1]))
    else $error("port C read lacks enable flag");
  bsr_ie_a: assert property (@(posedge clk) disable iff (!rst_n)
    bsr && bsr_sel == sphc_pkg::PC_ACK_A && ch_active[sphc_pkg::CH_AO]
    |=> ie_reg[2] == $past(bsr_val))
    else $error("bit command missed output enable");
  latch_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    ch_active[sphc_pkg::CH_AI] && !stb_a_n && !mode_set |=> a_in_reg == $past(pa_sync))
    else $error("input latch not loaded");
  read_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_req.rd |=> rdata_reg == 8'h00)
    else $error("read data outside read slot");
  irq_a_c: cover property (@(posedge clk) disable iff (!rst_n)
    a_bidir && ch_irq[sphc_pkg::CH_AI] ##[1:20] ch_irq[sphc_pkg::CH_AO]);
  drive_c: cover property (@(posedge clk) disable iff (!rst_n) a_bidir && pa_en_reg);
  b_full_c: cover property (@(posedge clk) disable iff (!rst_n)
    ch_full[sphc_pkg::CH_B] ##1 rd_b ##1 !ch_full[sphc_pkg::CH_B]);

endmodule : sphc_top

// ===== bench/sphc_periph.sv
// Peripheral model: strobes bytes into port A and acknowledges port A output.
// Assumes the bench pulses send for one clock and obf_n idles high.
`timescale 1ns/1ps
module sphc_periph (
  input logic clk,
  input logic send,
  input logic [7:0] send_data,
  input logic [7:0] pa_drive,
  input logic obf_n,
  output logic [7:0] pa_pin,
  output logic stb_n,
  output logic ack_n,
  output logic [7:0] taken
);
  // ==========================================================================
  // Strobe in; a released bus shows the inverse so stale data cannot pass
  initial begin
    pa_pin = 8'h00;
    stb_n = 1'b1;
    ack_n = 1'b1;
    taken = 8'h00;
  end
  always @(posedge clk) begin
    if (send) begin
      pa_pin <= send_data;
      stb_n <= 1'b0;
      repeat (3) @(posedge clk);
      stb_n <= 1'b1;
      repeat (2) @(posedge clk);
      pa_pin <= ~send_data;
    end
  end
  // Slow acknowledge; held long enough to outlast the pin latency
  always @(posedge clk) begin
    if (obf_n === 1'b0 && ack_n) begin
      repeat (2) @(posedge clk);
      taken <= pa_drive;
      ack_n <= 1'b0;
      repeat (6) @(posedge clk);
      ack_n <= 1'b1;
    end
  end
endmodule : sphc_periph

// ===== bench/tb_top.sv
// Testbench: reset, strobed input, strobed output and bidirectional port A.
// Assumes the peripheral model in sphc_periph.sv.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sphc_pkg::sphc_bus_req_t bus_req = '0;
  logic [7:0] rdata, pa_drive, pb_drive, pc_drive, pc_en, pa_pin, taken, d;
  logic pa_en, pb_en, stb_n, ack_n, seen;
  logic send = 1'b0;
  logic [7:0] send_data = 8'h00;
  int failures = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  sphc_top dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .pa_pin(pa_pin), .pa_drive(pa_drive), .pa_en(pa_en), .pb_pin(8'hFF),
    .pb_drive(pb_drive), .pb_en(pb_en), .pc_pin({1'b1, ack_n, 1'b1, stb_n, 4'hF}),
    .pc_drive(pc_drive), .pc_en(pc_en));
  sphc_periph peer (.clk(clk), .send(send), .send_data(send_data), .pa_drive(pa_drive),
    .obf_n(pc_en[7] ? pc_drive[7] : 1'b1), .pa_pin(pa_pin), .stb_n(stb_n),
    .ack_n(ack_n), .taken(taken));
  // ==========================================================================
  // Shared helpers
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= {a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr
  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [1:0] a);
    @(posedge clk);
    bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // Bounded wait on a port C line; a hang ends the run
  task automatic wait_pc(input int i, input logic v);
    int n;
    n = 0;
    while (pc_drive[i] !== v && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    check($sformatf("pc_drive[%0d]", i), {7'h00, v}, {7'h00, pc_drive[i]});
    if (n == 60) finish_test();
  endtask : wait_pc
  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    bus_rd(2'h3);
    check("control", 8'h9B, d);
    check("pa_en", 8'h00, {7'h00, pa_en});
    $display("reset test done");
  endtask : test_reset
  task automatic test_input();
    // Upper lines as inputs so line 7 never looks like a full output buffer
    bus_wr(2'h3, 8'hB8);
    bus_wr(2'h3, 8'h09);
    bus_rd(2'h2);
    check("enable A in", 8'h01, {7'h00, d[4]});
    @(posedge clk);
    send <= 1'b1;
    send_data <= 8'hA5;
    @(posedge clk);
    send <= 1'b0;
    wait_pc(5, 1'b1);
    wait_pc(3, 1'b1);
    bus_rd(2'h0);
    check("port A in", 8'hA5, d);
    wait_pc(5, 1'b0);
    wait_pc(3, 1'b0);
    $display("strobed input test done");
  endtask : test_input
  task automatic test_output();
    bus_wr(2'h3, 8'hA0);
    bus_rd(2'h2);
    check("enable after mode", 8'h00, {7'h00, d[6]});
    bus_wr(2'h3, 8'h0D);
    bus_wr(2'h0, 8'h3C);
    wait_pc(7, 1'b0);
    check("pa_drive", 8'h3C, pa_drive);
    wait_pc(7, 1'b1);
    wait_pc(3, 1'b1);
    check("taken", 8'h3C, taken);
    bus_wr(2'h0, 8'h5A);
    wait_pc(3, 1'b0);
    $display("strobed output test done");
  endtask : test_output
  task automatic test_bidir();
    repeat (20) @(posedge clk);
    bus_wr(2'h3, 8'hC0);
    @(posedge clk);
    #1;
    check("bidir idle en", 8'h00, {7'h00, pa_en});
    bus_wr(2'h0, 8'h77);
    seen = 1'b0;
    repeat (20) begin
      @(posedge clk);
      seen = seen | (pa_en & ~(pa_drive !== 8'h77));
    end
    check("bidir drive seen", 8'h01, {7'h00, seen});
    check("bidir released", 8'h00, {7'h00, pa_en});
    check("bidir taken", 8'h77, taken);
    $display("bidirectional test done");
  endtask : test_bidir
  // Group B strobed output beside a bidirectional group A
  task automatic test_port_b();
    bus_wr(2'h3, 8'hC4);
    bus_wr(2'h3, 8'h05);
    bus_rd(2'h2);
    check("enable B", 8'h01, {7'h00, d[2]});
    bus_wr(2'h1, 8'h96);
    wait_pc(1, 1'b0);
    check("pb_drive", 8'h96, pb_drive);
    check("pb_en", 8'h01, {7'h00, pb_en});
    check("pc_en", 8'hAB, pc_en);
    wait_pc(0, 1'b0);
    bus_wr(2'h3, 8'h03);
    wait_pc(1, 1'b1);
    wait_pc(0, 1'b1);
    bus_wr(2'h2, 8'h00);
    bus_rd(2'h2);
    check("port C guard", 8'h07, d & 8'h07);
    $display("port B test done");
  endtask : test_port_b
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_input();
    test_output();
    test_bidir();
    test_port_b();
    finish_test();
  end
endmodule : tb_top
